// ### logic/cbd_pkg.sv
// package for the can buffer direction and interrupt enable block
// assumes a wishbone classic slave with 32-bit data, one register a word
package cbd_pkg;
    // ==========================================================
    // register map, byte addresses
    localparam logic [3:0] CBD_ADDR_DIR = 4'h0;
    localparam logic [3:0] CBD_ADDR_IEN = 4'h4;
    localparam logic [3:0] CBD_ADDR_MODE = 4'h8;
    localparam logic [3:0] CBD_ADDR_STAT = 4'hC;
    // ==========================================================
    // reset values and field positions
    localparam logic [7:0] CBD_DIR_RST = 8'h00;
    localparam logic [7:0] CBD_IEN_RST = 8'h00;
    localparam logic [1:0] CBD_MODE_RST = 2'h0;
    localparam int CBD_DIR_LSB = 2;
    localparam int CBD_NBUF = 6;
    localparam int CBD_IEN_IRX = 7;
    localparam int CBD_IEN_WAKE = 6;
    localparam int CBD_IEN_ERR = 5;
    localparam int CBD_IEN_TXG = 4;
    localparam int CBD_IEN_TX1 = 3;
    localparam int CBD_IEN_TX0 = 2;
    localparam int CBD_IEN_RXG = 1;
    localparam int CBD_IEN_FIFO = 0;
    // ==========================================================
    // operating modes
    typedef enum logic [1:0] {
        CBD_MODE_LEGACY = 2'h0,
        CBD_MODE_ENH = 2'h1,
        CBD_MODE_FIFO = 2'h2
    } cbd_mode_t;
endpackage : cbd_pkg

// ### logic/cbd_alloc.sv
// buffer allocator: samples direction bits when a buffer is allocated
// assumes alloc requests come from logic on the same clock
`timescale 1ns/1ps
module cbd_alloc (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic alloc_i,
    input wire logic [2:0] alloc_buf_i,
    input wire logic [cbd_pkg::CBD_NBUF-1:0] dir_i,
    output logic alloc_tx_o,
    output logic alloc_rx_o
);
    import cbd_pkg::*;
    typedef struct packed {
        logic tx;
        logic rx;
    } cbd_alloc_st_t;
    cbd_alloc_st_t s_q, s_d;
    logic valid_buf;
    assign valid_buf = (alloc_buf_i < 3'(CBD_NBUF));
    // ==========================================================
    // grant one-cycle pulse to tx scheduler or rx acceptance
    always_comb begin
        s_d = '0;
        if (alloc_i && valid_buf) begin
            s_d.tx = dir_i[alloc_buf_i]; // R8
            s_d.rx = !dir_i[alloc_buf_i]; // R8
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign alloc_tx_o = s_q.tx;
    assign alloc_rx_o = s_q.rx;
endmodule : cbd_alloc

// ### logic/cbd_top.sv
// can buffer direction select and peripheral interrupt enable three
// assumes a wishbone classic master on clk_i; events from the can engine
// What this block does
// R1 - bits 7..2 set tx direction for buffers 5..0; clear is rx; reset 0
// R2 - bits 1..0 of direction register read zero and ignore writes
// R3 - direction register exists only in modes 1 and 2
// R4 - invalid message interrupt passes only when enable bit 7 is set
// R5 - std-id high byte writable in tx direction, read-only in rx
// R6 - in modes 1,2 bit 4 gates all tx buffer interrupts with per-buffer; here legacy tx 1,0 use bits 3,2 and legacy tx 2 is dropped
// R7 - in modes 1,2 bit 1 gates rx buffer interrupts with per-buffer
// R8 - direction sampled at allocation chooses tx scheduler or rx logic
`timescale 1ns/1ps
module cbd_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic irx_evt_i,
    input wire logic wake_evt_i,
    input wire logic err_evt_i,
    input wire logic [cbd_pkg::CBD_NBUF-1:0] buf_evt_i,
    input wire logic [cbd_pkg::CBD_NBUF-1:0] buf_ien_i,
    input wire logic [2:0] legacy_tx_evt_i,
    input wire logic [1:0] legacy_rx_evt_i,
    input wire logic fifo_wm_evt_i,
    input wire logic alloc_i,
    input wire logic [2:0] alloc_buf_i,
    output logic alloc_tx_o,
    output logic alloc_rx_o,
    output logic [cbd_pkg::CBD_NBUF-1:0] buffer_tx_direction_bits_o,
    output logic [cbd_pkg::CBD_NBUF-1:0] std_id_high_wr_en_o,
    output logic irq_o
);
    import cbd_pkg::*;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] ien;
        logic [1:0] mode;
        logic ack;
        logic [31:0] rdat;
        logic irq;
    } cbd_top_st_t;
    cbd_top_st_t s_q, s_d;
    logic enh;
    logic req;
    logic [CBD_NBUF-1:0] tx_hit;
    logic [CBD_NBUF-1:0] rx_hit;
    logic irq_any;
    logic [CBD_NBUF-1:0] dir_bits;
    // ==========================================================
    // decode helpers
    assign enh = (s_q.mode == CBD_MODE_ENH) || (s_q.mode == CBD_MODE_FIFO);
    assign req = cyc_i && stb_i && !s_q.ack;
    assign dir_bits = enh ? s_q.dir[7:CBD_DIR_LSB] : '0; // R3
    // ==========================================================
    // per-buffer gated hits, split by direction
    genvar g;
    generate
        for (g = 0; g < CBD_NBUF; g++) begin : g_buf
            assign tx_hit[g] = buf_evt_i[g] && buf_ien_i[g] && dir_bits[g];
            assign rx_hit[g] = buf_evt_i[g] && buf_ien_i[g] && !dir_bits[g];
            // id byte locked while buffer receives
            assign std_id_high_wr_en_o[g] = enh && dir_bits[g]; // R5
        end
    endgenerate
    // ==========================================================
    // interrupt combine; bit layout follows operating mode
    always_comb begin
        irq_any = (irx_evt_i && s_q.ien[CBD_IEN_IRX]) // R4
            || (wake_evt_i && s_q.ien[CBD_IEN_WAKE])
            || (err_evt_i && s_q.ien[CBD_IEN_ERR]);
        if (enh) begin
            irq_any = irq_any
                || (s_q.ien[CBD_IEN_TXG] && (|tx_hit)) // R6
                || (s_q.ien[CBD_IEN_RXG] && (|rx_hit)) // R7
                || (legacy_tx_evt_i[1] && s_q.ien[CBD_IEN_TX1])
                || (legacy_tx_evt_i[0] && s_q.ien[CBD_IEN_TX0])
                || (fifo_wm_evt_i && s_q.ien[CBD_IEN_FIFO]);
        end else begin
            irq_any = irq_any
                || (legacy_tx_evt_i[2] && s_q.ien[CBD_IEN_TXG])
                || (legacy_tx_evt_i[1] && s_q.ien[CBD_IEN_TX1])
                || (legacy_tx_evt_i[0] && s_q.ien[CBD_IEN_TX0])
                || (legacy_rx_evt_i[1] && s_q.ien[CBD_IEN_RXG])
                || (legacy_rx_evt_i[0] && s_q.ien[CBD_IEN_FIFO]);
        end
    end
    // ==========================================================
    // wishbone slave: one wait-state answer, registered a cycle later
    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        s_d.irq = irq_any;
        s_d.rdat = '0;
        if (req && we_i && sel_i[0]) begin
            case (adr_i)
                CBD_ADDR_DIR: begin
                    // low two bits hold no storage
                    if (enh) begin
                        s_d.dir = {dat_i[7:CBD_DIR_LSB], 2'h0}; // R1 R2 R3
                    end
                end
                CBD_ADDR_IEN: begin
                    s_d.ien = dat_i[7:0]; // R4
                end
                CBD_ADDR_MODE: begin
                    // mode 3 is not defined, keep old mode
                    if (dat_i[1:0] != 2'h3) begin
                        s_d.mode = dat_i[1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (req && !we_i) begin
            case (adr_i)
                CBD_ADDR_DIR: s_d.rdat = enh ? {24'h0, s_q.dir} : '0; // R3
                CBD_ADDR_IEN: s_d.rdat = {24'h0, s_q.ien};
                CBD_ADDR_MODE: s_d.rdat = {30'h0, s_q.mode};
                CBD_ADDR_STAT: s_d.rdat = {26'h0, tx_hit | rx_hit};
                default: s_d.rdat = '0;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.dir <= CBD_DIR_RST; // R1
            s_q.ien <= CBD_IEN_RST;
            s_q.mode <= CBD_MODE_RST;
        end else begin
            s_q <= s_d;
        end
    end
    // ==========================================================
    // allocator and outputs
    cbd_alloc u_alloc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .alloc_i(alloc_i && enh),
        .alloc_buf_i(alloc_buf_i),
        .dir_i(dir_bits),
        .alloc_tx_o(alloc_tx_o),
        .alloc_rx_o(alloc_rx_o)
    );
    assign dat_o = s_q.rdat;
    assign ack_o = s_q.ack;
    assign irq_o = s_q.irq;
    assign buffer_tx_direction_bits_o = dir_bits;
endmodule : cbd_top

// ### verif/cbd_checker.sv
// port timing checks for the buffer direction and irq enable block
// assumes it is bound to cbd_top and shares its single clock
`timescale 1ns/1ps
module cbd_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic alloc_i,
    input wire logic [2:0] alloc_buf_i,
    input wire logic alloc_tx_o,
    input wire logic alloc_rx_o,
    input wire logic [5:0] buffer_tx_direction_bits_o,
    input wire logic [5:0] std_id_high_wr_en_o
);
    // ======================================================
    // mode mirror taken from the bus, so the checks know when the
    // direction register is hidden and allocation is blocked
    logic enh_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enh_q <= 1'b0;
        end else if (cyc_i && stb_i && !ack_o && we_i && sel_i[0]
            && adr_i == 4'h8 && dat_i[1:0] != 2'h3) begin
            enh_q <= (dat_i[1:0] != 2'h0);
        end
    end
    // ======================================================
    // bus handshake and read data
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing after request");
    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    // idle data must be zero so stale reads never leak
    a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    a_dir_low_zero: assert property (
        ack_o && !we_i && adr_i == 4'h0 |-> dat_o[1:0] == 2'h0)
        else $error("direction low bits not zero");
    // ======================================================
    // allocation and id-high write enables
    a_alloc_tx_dir: assert property (
        alloc_i && alloc_buf_i < 3'h6
        && buffer_tx_direction_bits_o[alloc_buf_i] |=> alloc_tx_o)
        else $error("tx buffer not given to scheduler");
    a_alloc_rx_dir: assert property (
        alloc_i && enh_q && alloc_buf_i < 3'h6
        && !buffer_tx_direction_bits_o[alloc_buf_i] |=> alloc_rx_o)
        else $error("rx buffer not given to acceptance");
    a_dir_hidden_mode0: assert property (
        !enh_q |-> buffer_tx_direction_bits_o == 6'h00)
        else $error("direction bits visible in mode 0");
    a_alloc_not_both: assert property (!(alloc_tx_o && alloc_rx_o))
        else $error("buffer allocated both ways");
    a_idhi_follows_dir: assert property (
        std_id_high_wr_en_o == buffer_tx_direction_bits_o)
        else $error("id-high write enable mismatch");
endmodule : cbd_checker

bind cbd_top cbd_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .alloc_i, .alloc_buf_i,
    .alloc_tx_o,
    .alloc_rx_o, .buffer_tx_direction_bits_o, .std_id_high_wr_en_o);

// ### verif/tb_top.sv
// self-checking bench for cbd_top over wishbone classic
// assumes a 25 MHz clock and a synchronous active-high reset
`timescale 1ns/1ps
module tb_top;
    import cbd_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, irx = 0;
    logic alloc = 0, ack_o, irq_o, atx, arx;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dat_o, rd;
    logic [5:0] bev = 6'h00, ben = 6'h00, dir_o, idw_o;
    logic [2:0] abuf = 3'h0;
    logic [3:0] sel = 4'h1;
    int num_errors = 0, comparisons = 0;
    always #20 clk_i = ~clk_i;
    // ======================================================
    // device; rarely used legacy events held quiet
    cbd_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
        .ack_o(ack_o), .irx_evt_i(irx), .wake_evt_i(1'b0),
        .err_evt_i(1'b0), .buf_evt_i(bev), .buf_ien_i(ben),
        .legacy_tx_evt_i(3'h0), .legacy_rx_evt_i(2'h0),
        .fifo_wm_evt_i(1'b0), .alloc_i(alloc), .alloc_buf_i(abuf),
        .alloc_tx_o(atx), .alloc_rx_o(arx),
        .buffer_tx_direction_bits_o(dir_o), .std_id_high_wr_en_o(idw_o),
        .irq_o(irq_o));
    // ======================================================
    // shared tasks
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h", $time, s, e);
        end
    endtask : chk
    // one classic cycle; waits for ack, bounded by the watchdog
    task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
        @(negedge clk_i);
    endtask : wb
    // set enables and events, look at irq one cycle later
    task ev(input logic [7:0] ie, input logic [5:0] e, input logic [5:0] n,
            input logic x, input logic exp);
        wb(1, CBD_ADDR_IEN, ie);
        @(posedge clk_i);
        bev <= e; ben <= n; irx <= x;
        repeat (2) @(negedge clk_i);
        chk(irq_o, exp);
    endtask : ev
    task al(input logic [2:0] b, input logic t);
        @(posedge clk_i);
        alloc <= 1; abuf <= b;
        @(posedge clk_i);
        alloc <= 0;
        @(negedge clk_i);
        chk({atx, arx}, {t, !t});
    endtask : al
    task complete_run;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // ======================================================
    // scenarios
    // reset values, then enhanced mode so the direction reg shows
    task t_reset;
        wb(0, CBD_ADDR_IEN, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(1, CBD_ADDR_MODE, 8'h01);
        wb(0, CBD_ADDR_DIR, 8'h00);
        chk(rd, 32'h0000_0000);
    endtask : t_reset
    // low bits never stored; id-high enables follow tx buffers
    task t_dir_rw;
        wb(1, CBD_ADDR_DIR, 8'hFF);
        wb(0, CBD_ADDR_DIR, 8'h00);
        chk(rd, 32'h0000_00FC);
        chk(idw_o, 6'h3F);
        wb(1, CBD_ADDR_DIR, 8'h57);
        wb(0, CBD_ADDR_DIR, 8'h00);
        chk(rd, 32'h0000_0054);
        chk(dir_o, 6'h15);
        chk(idw_o, 6'h15);
    endtask : t_dir_rw
    // byte lane 0 off drops the write; an unmapped word reads zero
    task t_lane;
        @(posedge clk_i);
        sel <= 4'h0;
        wb(1, CBD_ADDR_DIR, 8'hFF);
        @(posedge clk_i);
        sel <= 4'h1;
        wb(0, CBD_ADDR_DIR, 8'h00);
        chk(rd, 32'h0000_0054);
        wb(0, 4'h2, 8'h00);
        chk(rd, 32'h0000_0000);
    endtask : t_lane
    // buffer 0 is tx, buffer 1 is rx after the 0x57 write
    task t_alloc;
        al(3'h0, 1);
        al(3'h1, 0);
    endtask : t_alloc
    // group enables gate per-buffer hits by direction
    task t_irq;
        ev(8'h00, 6'h00, 6'h00, 1, 0);
        ev(8'h80, 6'h00, 6'h00, 1, 1);
        ev(8'h00, 6'h01, 6'h01, 0, 0);
        ev(8'h10, 6'h01, 6'h01, 0, 1);
        ev(8'h10, 6'h01, 6'h00, 0, 0);
        ev(8'h10, 6'h02, 6'h02, 0, 0);
        ev(8'h02, 6'h02, 6'h02, 0, 1);
    endtask : t_irq
    // mode 0 hides the direction reg and drops writes but keeps its
    // contents; mode 2 shows it again; a mode 3 write is refused
    task t_modes;
        wb(1, CBD_ADDR_MODE, 8'h00);
        wb(0, CBD_ADDR_DIR, 8'h00);
        chk(rd, 32'h0000_0000);
        chk(dir_o, 6'h00);
        chk(idw_o, 6'h00);
        wb(1, CBD_ADDR_DIR, 8'hFF);
        wb(1, CBD_ADDR_MODE, 8'h02);
        chk(dir_o, 6'h15);
        wb(0, CBD_ADDR_DIR, 8'h00);
        chk(rd, 32'h0000_0054);
        wb(1, CBD_ADDR_MODE, 8'h03);
        wb(0, CBD_ADDR_MODE, 8'h00);
        chk(rd, 32'h0000_0002);
    endtask : t_modes
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        t_reset();
        t_dir_rw();
        t_lane();
        t_alloc();
        t_irq();
        t_modes();
        complete_run();
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
endmodule : tb_top
